// [include/wdnmi_consts.svh]
`ifndef WDNMI_CONSTS_SVH
`define WDNMI_CONSTS_SVH
// Register bus shape
`define WDNMI_ADDR_W 16
`define WDNMI_DATA_W 4
// Register addresses
`define WDNMI_CTRL_ADDR 16'hff07
`define WDNMI_STAT_ADDR 16'hff08
`define WDNMI_MASK_ADDR 16'hff09
`define WDNMI_CNT_ADDR 16'hff0a
// Control field positions and reset values
`define WDNMI_BIT_RESTART 0
`define WDNMI_BIT_RUN 1
`define WDNMI_RUN_RST 1'b1
`define WDNMI_MASK_RST 4'h0
// Status and mask field positions
`define WDNMI_EV_TIMEOUT 0
`define WDNMI_EV_TAKEN 1
// Counter and tick timing
`define WDNMI_CNT_W 10
`define WDNMI_OSC_HZ 32768
`define WDNMI_TICK_HZ 256
`define WDNMI_OSC_DIV (`WDNMI_OSC_HZ / `WDNMI_TICK_HZ)
// Interrupt vector
`define WDNMI_PC_W 16
`define WDNMI_NMI_VECTOR 16'h0100
`endif

// [include/wdnmi_pkg.sv]
package wdnmi_pkg;
	// Interrupt gate states, one-hot
	typedef enum logic [1:0] {
		WDNMI_GATE_IDLE = 2'b01,
		WDNMI_GATE_PEND = 2'b10
	} wdnmi_gate_e;
endpackage

// [rtl/wdnmi_tick_div.sv]
`timescale 1ns/100ps
`include "wdnmi_consts.svh"
module wdnmi_tick_div #(
	parameter int DIV = `WDNMI_OSC_DIV
) (
	input wire logic clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic osc_pin, // Low-speed oscillator pin
	output logic tick_o // One-cycle 256 Hz enable
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic sync1_r, sync2_r, prev_r;
	logic [CW-1:0] div_r, div_nxt;

	// Edge of the synchronised oscillator and divide-by-DIV wrap
	wire osc_rise = sync2_r & ~prev_r;
	wire div_wrap = osc_rise && (div_r == LAST);
	assign div_nxt = div_wrap ? '0 : (osc_rise ? div_r + 1'b1 : div_r);

	// Two-stage synchroniser, edge history and divider
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
			div_r <= '0;
			tick_o <= 1'b0;
		end else begin
			sync1_r <= osc_pin;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			div_r <= div_nxt;
			tick_o <= div_wrap; // [R01]
		end
	end

	AST_TICK_FROM_EDGE: assert property (@(posedge clk) disable iff (!reset_n) // [R01]
		tick_o |-> $past(osc_rise) && ($past(div_r) == LAST))
		else $error("tick without a completed oscillator division");
endmodule

// [rtl/wdnmi_nmi_gate.sv]
`timescale 1ns/100ps
`include "wdnmi_consts.svh"
module wdnmi_nmi_gate (
	input wire logic clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic nmi_req, // Timeout pulse
	input wire logic cpu_halted, // Core sits in halt
	input wire logic cpu_boundary, // Core at an instruction boundary
	input wire logic sp_low_wr, // Low stack pointer half written
	input wire logic sp_high_wr, // High stack pointer half written
	output logic take_o, // Interrupt accepted, pulse
	output logic [`WDNMI_PC_W-1:0] vector_o, // Vector loaded on accept
	output logic wake_o, // Halt released, pulse
	output logic mask_o // Stack reload mask state
);
	wdnmi_pkg::wdnmi_gate_e state_r, state_nxt;
	logic seen_lo_r, seen_hi_r;

	// Stack pointer pairing; any lone half write masks again
	wire lo_seen = seen_lo_r | sp_low_wr;
	wire hi_seen = seen_hi_r | sp_high_wr;
	wire pair_done = lo_seen & hi_seen;
	wire mask_nxt = pair_done ? 1'b0 : ((sp_low_wr | sp_high_wr) ? 1'b1 : mask_o); // [R07]
	// Accept ignores the interrupt-enable flag entirely
	wire take_w = (state_r == wdnmi_pkg::WDNMI_GATE_PEND) && !mask_o && (cpu_boundary || cpu_halted); // [R06] [R07]

	// Pending state; a new request beside an accept keeps it pending
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			wdnmi_pkg::WDNMI_GATE_IDLE: state_nxt = nmi_req ? wdnmi_pkg::WDNMI_GATE_PEND : wdnmi_pkg::WDNMI_GATE_IDLE;
			wdnmi_pkg::WDNMI_GATE_PEND: state_nxt = (take_w && !nmi_req) ? wdnmi_pkg::WDNMI_GATE_IDLE : state_r;
			default: state_nxt = wdnmi_pkg::WDNMI_GATE_IDLE;
		endcase
	end

	// Gate registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r <= wdnmi_pkg::WDNMI_GATE_IDLE;
			mask_o <= 1'b1;
			seen_lo_r <= 1'b0;
			seen_hi_r <= 1'b0;
			take_o <= 1'b0;
			wake_o <= 1'b0;
			vector_o <= '0;
		end else begin
			state_r <= state_nxt;
			mask_o <= mask_nxt;
			seen_lo_r <= lo_seen & ~pair_done;
			seen_hi_r <= hi_seen & ~pair_done;
			take_o <= take_w;
			wake_o <= take_w & cpu_halted; // [R05]
			if (take_w)
				vector_o <= `WDNMI_NMI_VECTOR; // [R08]
		end
	end

	AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
		mask_o |=> !take_o)
		else $error("interrupt accepted in mask state");
	AST_VECTOR: assert property (@(posedge clk) disable iff (!reset_n) // [R08]
		take_o |-> vector_o == `WDNMI_NMI_VECTOR)
		else $error("accept without the fixed vector");
	AST_HALT_WAKE: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
		(state_r == wdnmi_pkg::WDNMI_GATE_PEND) && !mask_o && cpu_halted |=> take_o && wake_o)
		else $error("halted core not woken by pending interrupt");
	AST_PAIR_UNMASK: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
		(sp_low_wr && !sp_high_wr && !seen_hi_r) ##1 (sp_high_wr && !sp_low_wr) |=> !mask_o)
		else $error("mask kept after stack pointer pair");
	COV_WAKE: cover property (@(posedge clk) disable iff (!reset_n) wake_o);
endmodule

// [rtl/wdnmi_top.sv]
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "wdnmi_consts.svh"
// Overview of operation
// [R01] Counter advances on a 256 Hz tick divided from the low-speed oscillator.
// [R02] Run enable is one after reset, so counting starts with no software action.
// [R03] Timeout is measured by a ten-stage binary counter on the tick.
// [R04] Overflow of the last stage raises the non-maskable interrupt, about 3-4 s.
// [R05] Counting continues during halt; the interrupt releases the halt.
// [R06] The interrupt is accepted even with the interrupt-enable flag clear.
// [R07] Held off in mask state until both stack pointer halves are written.
// [R08] Acceptance vectors execution to the fixed address 0100h.
// [R09] Control register at watchdog_control: run enable bit 1, restart bit 0.
// [R10] Run enable zero stops the counter and suppresses the interrupt.
// [R11] Writing one to run enable starts counting; it reads back as written.
// [R12] Writing one to restart clears the counter; counting resumes from zero.
// [R13] Restart is write-only: zero does nothing, reads give zero.
// [R14] Upper two control bits ignore writes and read zero.
// [R15] Software must restart the watchdog within three seconds while enabled.
// [R16] Software not using it must clear run enable before the first timeout.
// [R17] Reset clears the counter; the request is one pulse; the counter wraps.
module wdnmi_top #(
	parameter int OSC_DIV = `WDNMI_OSC_DIV,
	parameter int CNT_W = `WDNMI_CNT_W
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic low_speed_oscillator, // Oscillator pin, asynchronous
	input wire logic [`WDNMI_ADDR_W-1:0] addr, // Register address
	input wire logic [`WDNMI_DATA_W-1:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [`WDNMI_DATA_W-1:0] rd_data, // Read data, cycle after strobe
	input wire logic cpu_halted, // Core in halt
	input wire logic cpu_boundary, // Core at instruction boundary
	input wire logic sp_low_wr, // Low stack pointer half written
	input wire logic sp_high_wr, // High stack pointer half written
	output logic nmi_req, // Timeout request pulse
	output logic nmi_take, // Interrupt accepted pulse
	output logic [`WDNMI_PC_W-1:0] nmi_vector, // Accept vector
	output logic halt_release, // Halt release pulse
	output logic stack_mask, // Stack reload mask state
	output logic irq // Level interrupt
);
	localparam logic [CNT_W-1:0] CNT_LAST = '1;
	localparam int DW = `WDNMI_DATA_W;

	logic tick;
	logic run_en_r, run_en_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic nmi_req_nxt;
	logic [DW-1:0] status_r, status_nxt;
	logic [DW-1:0] mask_r, mask_nxt;
	logic [DW-1:0] rd_nxt;
	logic irq_nxt;

	// Tick source from the oscillator pin
	wdnmi_tick_div #(
		.DIV(OSC_DIV)
	) u_tick (
		.clk(clk),
		.reset_n(reset_n),
		.osc_pin(low_speed_oscillator),
		.tick_o(tick)
	);

	// Acceptance by the core
	wdnmi_nmi_gate u_gate (
		.clk(clk),
		.reset_n(reset_n),
		.nmi_req(nmi_req),
		.cpu_halted(cpu_halted),
		.cpu_boundary(cpu_boundary),
		.sp_low_wr(sp_low_wr),
		.sp_high_wr(sp_high_wr),
		.take_o(nmi_take),
		.vector_o(nmi_vector),
		.wake_o(halt_release),
		.mask_o(stack_mask)
	);

	// Address decode
	wire sel_ctrl = (addr == `WDNMI_CTRL_ADDR); // [R09]
	wire sel_stat = (addr == `WDNMI_STAT_ADDR);
	wire sel_mask = (addr == `WDNMI_MASK_ADDR);
	wire sel_cnt = (addr == `WDNMI_CNT_ADDR);
	wire wr_ctrl = wr_en && sel_ctrl;
	wire wr_mask = wr_en && sel_mask;
	wire rd_stat = rd_en && sel_stat;

	// Control writes; bits 3:2 are not stored at all
	wire restart = wr_ctrl && wr_data[`WDNMI_BIT_RESTART]; // [R12] [R13] [R14]
	assign run_en_nxt = wr_ctrl ? wr_data[`WDNMI_BIT_RUN] : run_en_r; // [R11]

	// Counting: restart wins over a tick, run enable gates the tick
	wire advance = tick && run_en_r && !restart; // [R01] [R05] [R10]
	wire overflow = advance && (cnt_r == CNT_LAST); // [R04]
	assign cnt_nxt = restart ? '0 : (advance ? cnt_r + 1'b1 : cnt_r); // [R03] [R12] [R17]
	assign nmi_req_nxt = overflow; // [R04] [R17]

	// Sticky events; the set beats a clearing read
	wire [DW-1:0] events = (DW'(overflow) << `WDNMI_EV_TIMEOUT) | (DW'(nmi_take) << `WDNMI_EV_TAKEN);
	assign status_nxt = (rd_stat ? '0 : status_r) | events;
	assign mask_nxt = wr_mask ? wr_data : mask_r;
	assign irq_nxt = |(status_nxt & mask_nxt);

	// Read multiplexer; unmapped addresses read zero
	assign rd_nxt = !rd_en ? '0 :
		sel_ctrl ? DW'(run_en_r) << `WDNMI_BIT_RUN : // [R11] [R13] [R14]
		sel_stat ? status_r :
		sel_mask ? mask_r :
		sel_cnt ? cnt_r[CNT_W-1 -: DW] :
		'0;

	// Control and counter state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			run_en_r <= `WDNMI_RUN_RST; // [R02]
			cnt_r <= '0; // [R17]
			nmi_req <= 1'b0;
		end else begin
			run_en_r <= run_en_nxt;
			cnt_r <= cnt_nxt;
			nmi_req <= nmi_req_nxt;
		end
	end

	// Register file outputs and interrupt line
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status_r <= '0;
			mask_r <= `WDNMI_MASK_RST;
			rd_data <= '0;
			irq <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rd_data <= rd_nxt;
			irq <= irq_nxt;
		end
	end

	// Checks on reset values
	AST_RESET_STATE: assert property (@(posedge clk) // [R02]
		!reset_n |=> run_en_r && (cnt_r == '0) && !nmi_req)
		else $error("reset did not leave watchdog running from zero");

	// Checks on counting
	AST_ADVANCE: assert property (@(posedge clk) disable iff (!reset_n) // [R03]
		tick && run_en_r && !restart |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("counter failed to advance on tick");
	AST_ONLY_ON_TICK: assert property (@(posedge clk) disable iff (!reset_n) // [R01]
		!tick && !restart |=> cnt_r == $past(cnt_r))
		else $error("counter moved without a tick");
	AST_DISABLED_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
		!run_en_r && !restart |=> (cnt_r == $past(cnt_r)) && !nmi_req)
		else $error("disabled watchdog moved or interrupted");
	AST_OVERFLOW_NMI: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
		tick && run_en_r && !restart && (cnt_r == CNT_LAST) |=> nmi_req && (cnt_r == '0))
		else $error("overflow did not raise request and wrap");
	AST_NMI_CAUSE: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
		nmi_req |-> $past(cnt_r) == CNT_LAST && $past(tick))
		else $error("request without overflow");
	AST_NMI_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
		nmi_req |=> !nmi_req)
		else $error("request longer than one cycle");

	// Checks on register access
	AST_RESTART_CLEARS: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
		wr_en && sel_ctrl && wr_data[`WDNMI_BIT_RESTART] |=> (cnt_r == '0) && !nmi_req)
		else $error("restart did not clear the counter");
	AST_RUN_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
		wr_en && sel_ctrl |=> run_en_r == $past(wr_data[`WDNMI_BIT_RUN]))
		else $error("run enable did not take the written value");
	AST_CTRL_READ: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		rd_en && sel_ctrl |=> rd_data == ({2'b00, $past(run_en_r), 1'b0}))
		else $error("control read shows wrong bits");
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
		irq == |$past(status_nxt & mask_nxt))
		else $error("interrupt line disagrees with status and mask");

	// Checks on the read port and the event registers
	AST_RD_IDLE_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		!rd_en |=> rd_data == '0)
		else $error("read data not zero outside a read");
	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && !(sel_ctrl || sel_stat || sel_mask || sel_cnt) |=> rd_data == '0)
		else $error("unmapped read returned data");
	AST_CNT_READ: assert property (@(posedge clk) disable iff (!reset_n)
		rd_en && sel_cnt |=> rd_data == $past(cnt_r[CNT_W-1 -: DW]))
		else $error("counter view read shows wrong bits");
	AST_STAT_READ: assert property (@(posedge clk) disable iff (!reset_n)
		rd_stat |=> rd_data == $past(status_r))
		else $error("status read shows wrong bits");
	AST_STAT_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
		overflow |=> status_r[`WDNMI_EV_TIMEOUT])
		else $error("timeout event lost against a clearing read");
	AST_STAT_STICKY: assert property (@(posedge clk) disable iff (!reset_n)
		!rd_stat && status_r[`WDNMI_EV_TIMEOUT] |=> status_r[`WDNMI_EV_TIMEOUT])
		else $error("timeout status cleared without a read");
	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		wr_mask |=> mask_r == $past(wr_data))
		else $error("mask register did not take the written value");
	AST_NMI_NEEDS_RUN: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
		nmi_req |-> $past(run_en_r) && !$past(restart))
		else $error("request while disabled or restarted");
	AST_HALT_COUNTS: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
		cpu_halted && tick && run_en_r && !restart |=> cnt_r != $past(cnt_r))
		else $error("counter stopped during halt");

	// Main scenarios
	COV_TIMEOUT: cover property (@(posedge clk) disable iff (!reset_n) nmi_req);
	COV_RESTART_ON_TICK: cover property (@(posedge clk) disable iff (!reset_n) restart && tick);
	COV_IRQ: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
	COV_HALT_TIMEOUT: cover property (@(posedge clk) disable iff (!reset_n) cpu_halted && nmi_req);
endmodule

// [test/wdnmi_core_model.sv]
`timescale 1ns/100ps
`include "wdnmi_consts.svh"
// Core side: boundary pacing, halt, stack pointer reload, vector fetch
module wdnmi_core_model (
	input wire logic clk, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic halt_go, // Bench asks for halt, pulse
	input wire logic sp_go, // Bench asks for a stack reload, pulse
	input wire logic nmi_take, // Accept pulse
	input wire logic halt_release, // Halt release pulse
	input wire logic [`WDNMI_PC_W-1:0] nmi_vector, // Accept vector
	output logic cpu_halted, // Halt level
	output logic cpu_boundary, // Boundary level
	output logic sp_low_wr, // Low half write pulse
	output logic sp_high_wr, // High half write pulse
	output logic [`WDNMI_PC_W-1:0] pc_r // Program counter
);
	// Interrupt enable flag is never set, so acceptance cannot lean on it
	logic int_en_r;
	// One core step per clock; boundary only every other cycle, so accepts may lag
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			int_en_r <= 1'b0;
			cpu_halted <= 1'b0;
			cpu_boundary <= 1'b0;
			sp_low_wr <= 1'b0;
			sp_high_wr <= 1'b0;
			pc_r <= 16'h0000;
		end else begin
			int_en_r <= 1'b0;
			cpu_boundary <= ~cpu_boundary & ~cpu_halted;
			sp_low_wr <= sp_go;
			sp_high_wr <= sp_low_wr;
			if (halt_release) begin
				cpu_halted <= 1'b0;
			end else if (halt_go) begin
				cpu_halted <= 1'b1;
			end
			if (nmi_take) begin
				pc_r <= nmi_vector;
			end
		end
	end
endmodule

// [test/test_watchdog_nmi_timer.sv]
`timescale 1ns/100ps
`include "wdnmi_consts.svh"
module test_watchdog_nmi_timer;
	logic clk = 1'b0, reset_n = 1'b0, low_speed_oscillator = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic halt_go = 1'b0, sp_go = 1'b0, rel_at_take = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [3:0] wr_data = 4'h0;
	logic [3:0] rd_data;
	logic nmi_req, nmi_take, halt_release, stack_mask, irq, cpu_halted, cpu_boundary, sp_low_wr, sp_high_wr;
	logic [15:0] nmi_vector, pc;
	int n_mismatch = 0, checked = 0, seed = 32'hcd2f, n_take = 0, n = 0, m_run = 1;
	// Model of the event registers: status bits set by timeout and accept, mask as written
	int m_stat = 0, m_mask = 0;
	// Clock, and an oscillator of four system cycles so a tick comes every eight
	initial forever #20 clk = ~clk;
	initial forever begin
		repeat (2) @(posedge clk);
		low_speed_oscillator <= ~low_speed_oscillator;
	end
	// Count accepts and note whether each one released a halt
	always @(posedge clk) begin
		if (nmi_take === 1'b1) begin
			n_take <= n_take + 1;
			rel_at_take <= halt_release;
		end
	end
	wdnmi_top #(.OSC_DIV(2), .CNT_W(10)) dut (.clk(clk), .reset_n(reset_n),
		.low_speed_oscillator(low_speed_oscillator), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .cpu_halted(cpu_halted), .cpu_boundary(cpu_boundary),
		.sp_low_wr(sp_low_wr), .sp_high_wr(sp_high_wr), .nmi_req(nmi_req), .nmi_take(nmi_take),
		.nmi_vector(nmi_vector), .halt_release(halt_release), .stack_mask(stack_mask), .irq(irq));
	wdnmi_core_model core (.clk(clk), .reset_n(reset_n), .halt_go(halt_go), .sp_go(sp_go),
		.nmi_take(nmi_take), .halt_release(halt_release), .nmi_vector(nmi_vector), .cpu_halted(cpu_halted),
		.cpu_boundary(cpu_boundary), .sp_low_wr(sp_low_wr), .sp_high_wr(sp_high_wr), .pc_r(pc));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		#1;
	endtask
	task rd(input logic [15:0] a, input logic [3:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(16'(rd_data), 16'(exp));
	endtask
	// Cycles until a timeout request, up to lim; a required one that never comes ends the run
	task wait_req(input int lim, input bit must, output int k);
		k = 0;
		while (nmi_req !== 1'b1 && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (must && k >= lim) begin
			chk(16'h0, 16'h1);
			tally_and_finish;
		end
	endtask
	task wait_take(input int lim);
		int start;
		int k;
		start = n_take;
		k = 0;
		while (n_take == start && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= lim) begin
			chk(16'h0, 16'h1);
			tally_and_finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(16'(stack_mask), 16'h1);
		rd(`WDNMI_CTRL_ADDR, 4'(m_run << 1));
		m_run = 0;
		wr(`WDNMI_CTRL_ADDR, {2'($random(seed)), 2'b01});
		rd(`WDNMI_CTRL_ADDR, 4'(m_run << 1));
		wait_req(10000, 1'b0, n);
		chk(16'(n), 16'd10000);
		rd(`WDNMI_STAT_ADDR, 4'(m_stat));
		rd(16'hff0b, 4'h0);
		m_mask = 3;
		wr(`WDNMI_MASK_ADDR, 4'(m_mask));
		rd(`WDNMI_MASK_ADDR, 4'(m_mask));
		m_run = 1;
		wr(`WDNMI_CTRL_ADDR, {2'($random(seed)), 2'b11});
		wait_req(9000, 1'b1, n);
		m_stat = m_stat | 1;
		chk(16'(n >= 8168 && n <= 8216), 16'h1);
		@(posedge clk);
		#1;
		chk(16'(nmi_req), 16'h0);
		rd(`WDNMI_CNT_ADDR, 4'h0);
		chk(16'(irq), 16'((m_stat & m_mask) != 0));
		repeat (20) @(posedge clk);
		#1;
		chk(16'(n_take), 16'h0);
		@(posedge clk);
		sp_go <= 1'b1;
		@(posedge clk);
		sp_go <= 1'b0;
		wait_take(20);
		m_stat = m_stat | 2;
		chk(nmi_vector, `WDNMI_NMI_VECTOR);
		chk(pc, `WDNMI_NMI_VECTOR);
		chk(16'(stack_mask), 16'h0);
		chk(16'(rel_at_take), 16'h0);
		rd(`WDNMI_STAT_ADDR, 4'(m_stat));
		m_stat = 0;
		rd(`WDNMI_STAT_ADDR, 4'(m_stat));
		chk(16'(irq), 16'((m_stat & m_mask) != 0));
		@(posedge clk);
		halt_go <= 1'b1;
		@(posedge clk);
		halt_go <= 1'b0;
		repeat (2000 + ($random(seed) & 1023)) @(posedge clk);
		wr(`WDNMI_CTRL_ADDR, 4'h3);
		wait_req(9000, 1'b1, n);
		m_stat = m_stat | 1;
		chk(16'(n >= 8168 && n <= 8216), 16'h1);
		wait_take(20);
		m_stat = m_stat | 2;
		chk(16'(rel_at_take), 16'h1);
		chk(16'(cpu_halted), 16'h0);
		chk(16'(irq), 16'((m_stat & m_mask) != 0));
		rd(`WDNMI_STAT_ADDR, 4'(m_stat));
		tally_and_finish;
	end
endmodule
